//--- hw/irpb_bank.sv
// Input priority register bank: two copies of the rank registers behind an APB slave.
// Assumes an APB master on pclk; selection logic downstream reads the rank and pick outputs.
//
// The implementer's own choice: the APB register port.

// Notes on behaviour
// - Register 0x18 holds input two rank high nibble, input one low nibble.
// - Register 0x19 holds input four rank high nibble, input three low nibble.
// - A smaller nonzero rank means the input is preferred.
// - A zero rank removes the input from automatic selection.
// - Ranks one to fifteen are all valid priorities.
// - Bank select bit 4 picks main copy when 0, auxiliary copy when 1.
module irpb_bank #(
   parameter logic [7:0] MAIN_ONE_TWO_RESET = irpb_pkg::RST_MAIN_PAIR_ONE_TWO,
   parameter logic [7:0] AUX_ONE_TWO_RESET = irpb_pkg::RST_AUX_PAIR_ONE_TWO
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic path_bank_select,
   output logic [15:0] main_timing_path_ranks,
   output logic [15:0] auxiliary_timing_path_ranks,
   output irpb_pkg::irpb_pick_s main_timing_path_pick,
   output irpb_pkg::irpb_pick_s auxiliary_timing_path_pick
);

   // ********************************************************************
   // State
   // ********************************************************************
   irpb_pkg::irpb_state_s st;
   irpb_pkg::irpb_state_s next_st;
   irpb_pkg::irpb_pick_s main_found;
   irpb_pkg::irpb_pick_s aux_found;
   logic setup;
   logic commit;
   logic hit_one_two;
   logic hit_three_four;
   logic hit_select;
   logic [7:0] sel_one_two;
   logic [7:0] sel_three_four;

   // ********************************************************************
   // Pickers
   // ********************************************************************
   // One picker per timing path, each looking at its own copy only.
   irpb_rank_pick u_main_pick (
      .ranks(st.main_rank),
      .pick(main_found)
   );

   irpb_rank_pick u_aux_pick (
      .ranks(st.aux_rank),
      .pick(aux_found)
   );

   // ********************************************************************
   // Decode
   // ********************************************************************
   // Setup is the first cycle of a transfer; commit is the access edge that completes it.
   assign setup = psel && !penable;
   assign commit = psel && penable && st.ready;
   assign hit_one_two = paddr == irpb_pkg::ADDR_PAIR_ONE_TWO;
   assign hit_three_four = paddr == irpb_pkg::ADDR_PAIR_THREE_FOUR;
   assign hit_select = paddr == irpb_pkg::ADDR_PATH_SELECT;
   // The selected copy is what software sees.
   assign sel_one_two = st.bank ? st.aux_rank[0] : st.main_rank[0];
   assign sel_three_four = st.bank ? st.aux_rank[1] : st.main_rank[1];

   // ********************************************************************
   // Next state
   // ********************************************************************
   // Answers every transfer in its first access cycle; unmapped addresses read zero with an error.
   always_comb begin
      next_st = st;
      next_st.ready = 1'b0;
      next_st.err = 1'b0;
      next_st.main_pick = main_found;
      next_st.aux_pick = aux_found;
      if (setup) begin
         next_st.ready = 1'b1;
         next_st.rdata = irpb_pkg::RDATA_ZERO;
         next_st.err = !(hit_one_two || hit_three_four || hit_select);
         if (!pwrite) begin
            if (hit_one_two) begin
               next_st.rdata = {24'h00_0000, sel_one_two};
            end else if (hit_three_four) begin
               next_st.rdata = {24'h00_0000, sel_three_four};
            end else if (hit_select) begin
               next_st.rdata = 32'(st.bank) << irpb_pkg::BANK_SELECT_BIT;
            end
         end
      end
      // Writes land at the access edge, in the selected copy only, when byte lane 0 is enabled.
      if (commit && pwrite && !st.err && pstrb[0]) begin
         if (hit_one_two) begin
            if (st.bank) begin
               next_st.aux_rank[0] = pwdata[7:0];
            end else begin
               next_st.main_rank[0] = pwdata[7:0];
            end
         end else if (hit_three_four) begin
            if (st.bank) begin
               next_st.aux_rank[1] = pwdata[7:0];
            end else begin
               next_st.main_rank[1] = pwdata[7:0];
            end
         end else if (hit_select) begin
            next_st.bank = pwdata[irpb_pkg::BANK_SELECT_BIT];
         end
      end
   end

   // ********************************************************************
   // Registers
   // ********************************************************************
   // Both copies come out of reset with their own defaults; main path selected.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
         st.main_rank[0] <= MAIN_ONE_TWO_RESET;
         st.aux_rank[0] <= AUX_ONE_TWO_RESET;
         st.main_rank[1] <= irpb_pkg::RST_MAIN_PAIR_THREE_FOUR;
         st.aux_rank[1] <= irpb_pkg::RST_AUX_PAIR_THREE_FOUR;
      end else begin
         st <= next_st;
      end
   end

   // ********************************************************************
   // Outputs
   // ********************************************************************
   // All outputs are state bits.
   assign prdata = st.rdata;
   assign pready = st.ready;
   assign pslverr = st.err;
   assign path_bank_select = st.bank;
   assign main_timing_path_ranks = st.main_rank;
   assign auxiliary_timing_path_ranks = st.aux_rank;
   assign main_timing_path_pick = st.main_pick;
   assign auxiliary_timing_path_pick = st.aux_pick;

   // ********************************************************************
   // Checks
   // ********************************************************************
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // Helper: rank of a given input within a 16-bit rank vector.
   function automatic logic [3:0] rank_of(input logic [15:0] r, input logic [1:0] i);
      rank_of = r[i*4 +: 4];
   endfunction

   // Helper: some nonzero rank beats the current main pick.
   logic main_beaten;
   always_comb begin
      main_beaten = 1'b0;
      for (int i = 0; i < irpb_pkg::NUM_INPUTS; i++) begin
         if (rank_of(st.main_rank, 2'(i)) != irpb_pkg::RANK_OFF &&
             rank_of(st.main_rank, 2'(i)) < rank_of(st.main_rank, main_found.index)) begin
            main_beaten = 1'b1;
         end
      end
   end

   sequence s_read_setup(logic [11:0] a);
      psel && !penable && !pwrite && paddr == a;
   endsequence

   sequence s_answer;
      pready ##1 !pready;
   endsequence

   a_read_lower_pair: assert property (
      s_read_setup(irpb_pkg::ADDR_PAIR_ONE_TWO) |=> prdata == {24'h00_0000, $past(sel_one_two)})
      else $error("read of pair one two returned wrong copy or layout");

   a_read_upper_pair: assert property (
      s_read_setup(irpb_pkg::ADDR_PAIR_THREE_FOUR) |=> (prdata[7:0] == $past(sel_three_four)) ##0 s_answer)
      else $error("read of pair three four wrong or answer not one cycle");

   a_read_aux_copy: assert property (
      psel && !penable && !pwrite && paddr == irpb_pkg::ADDR_PAIR_ONE_TWO && st.bank
      |=> (prdata[7:0] == $past(st.aux_rank[0])) ##0 s_answer)
      else $error("read with auxiliary bank selected did not return the auxiliary copy");

   a_best_is_smallest: assert property (
      main_found.valid |-> !main_beaten)
      else $error("main pick is not the smallest nonzero rank");

   a_zero_never_picked: assert property (
      main_timing_path_pick.valid |-> rank_of($past(st.main_rank), main_timing_path_pick.index) != 4'h0)
      else $error("main pick points at a disabled input");

   a_aux_zero_skipped: assert property (
      auxiliary_timing_path_pick.valid |-> rank_of($past(st.aux_rank), auxiliary_timing_path_pick.index) != 4'h0)
      else $error("aux pick points at a disabled input");

   a_nonzero_is_valid: assert property (
      auxiliary_timing_path_ranks != 16'h0000 |=> auxiliary_timing_path_pick.valid)
      else $error("aux path has a nonzero rank but no pick");

   a_bank_follows_write: assert property (
      commit && pwrite && hit_select && !pslverr && pstrb[0]
      |=> path_bank_select == $past(pwdata[irpb_pkg::BANK_SELECT_BIT]))
      else $error("bank select did not follow the write");

   a_main_write_only: assert property (
      commit && pwrite && hit_one_two && !path_bank_select && pstrb[0]
      |=> $stable(auxiliary_timing_path_ranks) && main_timing_path_ranks[7:0] == $past(pwdata[7:0]))
      else $error("main write touched aux copy or was lost");

   a_aux_write_only: assert property (
      commit && pwrite && hit_three_four && path_bank_select && pstrb[0]
      |=> $stable(main_timing_path_ranks) && auxiliary_timing_path_ranks[15:8] == $past(pwdata[7:0]))
      else $error("aux write touched main copy or was lost");

endmodule

//--- hw/irpb_pkg.sv
// Package for the input priority register bank: register map, field layout, reset values and shared types.
// Assumes an APB slave with 32-bit data and word-aligned registers, one clock and an active-low reset.
package irpb_pkg;

   // ********************************************************************
   // Register map
   // ********************************************************************
   // Printed offsets are register indices; the byte address is four times the index.
   localparam logic [9:0] IDX_PAIR_ONE_TWO = 10'h018;
   localparam logic [9:0] IDX_PAIR_THREE_FOUR = 10'h019;
   localparam logic [9:0] IDX_PATH_SELECT = 10'h04B;
   localparam int ADDR_W = 12;
   localparam logic [11:0] ADDR_PAIR_ONE_TWO = {IDX_PAIR_ONE_TWO, 2'b00};
   localparam logic [11:0] ADDR_PAIR_THREE_FOUR = {IDX_PAIR_THREE_FOUR, 2'b00};
   localparam logic [11:0] ADDR_PATH_SELECT = {IDX_PATH_SELECT, 2'b00};

   // ********************************************************************
   // Field layout
   // ********************************************************************
   localparam int RANK_W = 4;
   localparam int NUM_INPUTS = 4;
   localparam int BANK_SELECT_BIT = 4;
   localparam logic [3:0] RANK_OFF = 4'h0;

   // ********************************************************************
   // Reset values
   // ********************************************************************
   localparam logic [7:0] RST_MAIN_PAIR_ONE_TWO = 8'h00;
   localparam logic [7:0] RST_AUX_PAIR_ONE_TWO = 8'h00;
   localparam logic [7:0] RST_MAIN_PAIR_THREE_FOUR = 8'h54;
   localparam logic [7:0] RST_AUX_PAIR_THREE_FOUR = 8'h00;
   localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

   // ********************************************************************
   // Types
   // ********************************************************************
   // One byte register: the higher-numbered input sits in the upper nibble.
   typedef struct packed {
      logic [3:0] upper;
      logic [3:0] lower;
   } irpb_pair_s;

   // Winner of a selection: valid flag and input index, zero based.
   typedef struct packed {
      logic valid;
      logic [1:0] index;
   } irpb_pick_s;

   // Whole state of the register bank.
   typedef struct packed {
      logic bank;
      irpb_pair_s [1:0] main_rank;
      irpb_pair_s [1:0] aux_rank;
      logic [31:0] rdata;
      logic ready;
      logic err;
      irpb_pick_s main_pick;
      irpb_pick_s aux_pick;
   } irpb_state_s;

endpackage

//--- hw/irpb_rank_pick.sv
// Priority picker: finds the input with the smallest nonzero rank among four.
// Assumes its ranks come from registers on the same clock; purely combinational.
module irpb_rank_pick (
   input wire logic [15:0] ranks,
   output irpb_pkg::irpb_pick_s pick
);

   // ********************************************************************
   // Search
   // ********************************************************************
   // Zero ranks are skipped; ties go to the lower-numbered input.
   always_comb begin
      logic [3:0] best;
      best = irpb_pkg::RANK_OFF;
      pick = '0;
      for (int i = 0; i < irpb_pkg::NUM_INPUTS; i++) begin
         if (ranks[i*4 +: 4] != irpb_pkg::RANK_OFF) begin
            if (!pick.valid || ranks[i*4 +: 4] < best) begin
               best = ranks[i*4 +: 4];
               pick.valid = 1'b1;
               pick.index = 2'(i);
            end
         end
      end
   end

endmodule

//--- dv/irpb_bank_test.sv
// Self-checking bench for the input priority register bank, driving its APB port directly.
// Assumes the bank answers each transfer with pready and registers its rank and pick outputs.
module irpb_bank_test;
   timeunit 1ns;
   timeprecision 1ps;

   // ********************************************************************
   // Signals, clock and design
   // ********************************************************************
   logic pclk, presetn, psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [3:0] pstrb;
   logic [31:0] prdata;
   logic pready, pslverr, path_bank_select;
   logic [15:0] main_ranks, aux_ranks;
   irpb_pkg::irpb_pick_s main_pick, aux_pick;
   int err_total = 0;
   int n_tests = 0;

   // Clock of 10 ns period.
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   irpb_bank i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .path_bank_select(path_bank_select), .main_timing_path_ranks(main_ranks),
      .auxiliary_timing_path_ranks(aux_ranks), .main_timing_path_pick(main_pick),
      .auxiliary_timing_path_pick(aux_pick));

   // ********************************************************************
   // Shared tasks
   // ********************************************************************
   // Compares one value and counts it; a mismatch is printed at once.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // One APB transfer; the request is held until the edge that samples pready high.
   task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data,
                      output logic [31:0] rdat, output logic err);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= data;
      @(posedge pclk);
      penable <= 1'b1;
      // The answer is sampled at the rising edge; data and error are taken at that same edge.
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rdat = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk({31'h0000_0000, pready === 1'b1}, 32'h0000_0001);
   endtask

   // Write with an expected error flag.
   task automatic wr(input logic [11:0] addr, input logic [31:0] data, input logic exp_err);
      logic [31:0] r;
      logic e;
      apb(1'b1, addr, data, r, e);
      chk({31'h0000_0000, e}, {31'h0000_0000, exp_err});
   endtask

   // Read and compare data and error flag.
   task automatic rdchk(input logic [11:0] addr, input logic [31:0] exp, input logic exp_err);
      logic [31:0] r;
      logic e;
      apb(1'b0, addr, 32'h0000_0000, r, e);
      chk(r, exp);
      chk({31'h0000_0000, e}, {31'h0000_0000, exp_err});
   endtask

   // Lets registered ranks and the pick one cycle behind them settle.
   task automatic settle();
      repeat (2) @(negedge pclk);
   endtask

   // ********************************************************************
   // Scenarios
   // ********************************************************************
   // Reset contents of both copies and the winner they give.
   task automatic t_reset();
      rdchk(irpb_pkg::ADDR_PAIR_ONE_TWO, 32'h0000_0000, 1'b0);
      rdchk(irpb_pkg::ADDR_PAIR_THREE_FOUR, 32'h0000_0054, 1'b0);
      chk({16'h0000, main_ranks}, 32'h0000_5400);
      chk({16'h0000, aux_ranks}, 32'h0000_0000);
      chk({29'h0000_0000, main_pick}, 32'h0000_0006);
      chk({29'h0000_0000, aux_pick}, 32'h0000_0000);
      chk({31'h0000_0000, path_bank_select}, 32'h0000_0000);
   endtask

   // Main copy writes: nibble placement, ordering, zero and top ranks.
   task automatic t_main();
      wr(irpb_pkg::ADDR_PAIR_ONE_TWO, 32'hA5A5_A521, 1'b0);
      rdchk(irpb_pkg::ADDR_PAIR_ONE_TWO, 32'h0000_0021, 1'b0);
      settle();
      chk({16'h0000, main_ranks}, 32'h0000_5421);
      chk({29'h0000_0000, main_pick}, 32'h0000_0004);
      wr(irpb_pkg::ADDR_PAIR_ONE_TWO, 32'h0000_0030, 1'b0);
      settle();
      chk({29'h0000_0000, main_pick}, 32'h0000_0005);
      wr(irpb_pkg::ADDR_PAIR_THREE_FOUR, 32'h0000_001F, 1'b0);
      settle();
      chk({16'h0000, main_ranks}, 32'h0000_1F30);
      chk({29'h0000_0000, main_pick}, 32'h0000_0007);
   endtask

   // Auxiliary copy through the bank select, main copy left alone.
   task automatic t_aux();
      wr(irpb_pkg::ADDR_PATH_SELECT, 32'h0000_0010, 1'b0);
      rdchk(irpb_pkg::ADDR_PATH_SELECT, 32'h0000_0010, 1'b0);
      chk({31'h0000_0000, path_bank_select}, 32'h0000_0001);
      rdchk(irpb_pkg::ADDR_PAIR_THREE_FOUR, 32'h0000_0000, 1'b0);
      wr(irpb_pkg::ADDR_PAIR_THREE_FOUR, 32'h0000_00E0, 1'b0);
      settle();
      chk({16'h0000, aux_ranks}, 32'h0000_E000);
      chk({16'h0000, main_ranks}, 32'h0000_1F30);
      chk({29'h0000_0000, aux_pick}, 32'h0000_0007);
      wr(irpb_pkg::ADDR_PATH_SELECT, 32'h0000_0000, 1'b0);
      rdchk(irpb_pkg::ADDR_PAIR_THREE_FOUR, 32'h0000_001F, 1'b0);
      chk({31'h0000_0000, path_bank_select}, 32'h0000_0000);
   endtask

   // Unmapped word: error, zero data, no change to the main copy.
   task automatic t_unmapped();
      rdchk(12'h068, 32'h0000_0000, 1'b1);
      wr(12'h068, 32'h0000_0077, 1'b1);
      settle();
      chk({16'h0000, main_ranks}, 32'h0000_1F30);
      // A write with byte lane 0 disabled is ignored without an error.
      @(posedge pclk);
      pstrb <= 4'hE;
      wr(irpb_pkg::ADDR_PAIR_ONE_TWO, 32'h0000_0077, 1'b0);
      pstrb <= 4'hF;
      settle();
      chk({16'h0000, main_ranks}, 32'h0000_1F30);
      rdchk(irpb_pkg::ADDR_PAIR_ONE_TWO, 32'h0000_0030, 1'b0);
   endtask

   // ********************************************************************
   // Sequence, watchdog and verdict
   // ********************************************************************
   // Prints the counts and the verdict, then ends the run.
   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Cuts a hang short well beyond the expected run length.
   initial begin
      #20000;
      err_total++;
      report_and_stop();
   end

   // Main sequence: reset for three cycles, then the scenarios.
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      pstrb = 4'hF;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      settle();
      t_reset();
      t_main();
      t_aux();
      t_unmapped();
      report_and_stop();
   end
endmodule
